/* File: design/frst_sequencer.sv */
// Function
// RULE1: Wait supply settle time after power before first select or output enable low.
// RULE2: After power-on, hold select and output enable high 20 ns before access.
// RULE3: Flash ignores select during warm reset; no access until sequence completes.
// RULE4: After restart release wait 50 ns newer, 200 ns older before select.
// RULE5: After warm reset of newer part keep select high 20 ns first.
// RULE6: Hold restart low 200 ns newer, 35 us older, both reset kinds.
// RULE7: At least 35 us from restart falling edge to first select low.
// RULE8: Restart low time plus release wait must cover assert-to-select time.
// RULE9: Toggle select actively for newer part; never tie it low.
// RULE10: Count each wait in clock cycles, rounded up, select and enable high.
`timescale 1ns/10ps
module frst_sequencer #(
   parameter int unsigned SUPPLY_NEW_CYC = frst_pkg::NEW_SUPPLY_SETTLE_CYC,
   parameter int unsigned SUPPLY_OLD_CYC = frst_pkg::OLD_SUPPLY_SETTLE_CYC,
   parameter int unsigned PULSE_OLD_CYC  = frst_pkg::OLD_PULSE_CYC,
   parameter int unsigned ASSERT_CYC     = frst_pkg::ASSERT_TO_SELECT_CYC
) (
   input  wire logic              sys_clk,       // 100 MHz clock.
   input  wire logic              arst_n,        // Asynchronous reset, active low.
   input  wire logic              newer_gen,     // High selects newer generation timing.
   input  wire logic              warm_req,      // Pulse asks for a warm restart.
   input  wire logic              acc_select,    // User access: drive select low.
   input  wire logic              acc_read,      // User access: drive output enable low.
   output frst_pkg::frst_pins_s   pins,          // Flash restart, select, output enable.
   output logic                   ready          // High once first access may begin.
);

   logic [frst_pkg::CNT_W-1:0] cnt_reg;
   logic [frst_pkg::CNT_W-1:0] cnt_next;
   frst_pkg::frst_state_e      state_reg;
   frst_pkg::frst_state_e      state_next;
   logic                       gen_reg;
   logic                       gen_next;
   frst_pkg::frst_pins_s       pins_reg;
   frst_pkg::frst_pins_s       pins_next;
   logic                       ready_reg;
   logic                       ready_next;

   // Power-up cannot know which part is fitted, so it waits the longer settle span.
   localparam int unsigned SETTLE_CYC = (SUPPLY_NEW_CYC > SUPPLY_OLD_CYC) ?
      SUPPLY_NEW_CYC : SUPPLY_OLD_CYC; // [RULE1]
   // Wait lengths chosen from gen_reg: newer after reset, else the generation captured at warm restart.
   wire [frst_pkg::CNT_W-1:0] pulse_len = gen_reg ?
      frst_pkg::CNT_W'(frst_pkg::NEW_PULSE_CYC) : frst_pkg::CNT_W'(PULSE_OLD_CYC); // [RULE6]
   wire [frst_pkg::CNT_W-1:0] release_min = gen_reg ?
      frst_pkg::CNT_W'(frst_pkg::NEW_RELEASE_CYC) :
      frst_pkg::CNT_W'(frst_pkg::OLD_RELEASE_CYC); // [RULE4]
   // Low time plus release wait must also reach the assert-to-select figure.
   wire [frst_pkg::CNT_W-1:0] release_gap = (ASSERT_CYC > pulse_len) ?
      frst_pkg::CNT_W'(ASSERT_CYC) - pulse_len : '0; // [RULE7] [RULE8]
   wire [frst_pkg::CNT_W-1:0] release_len =
      (release_gap > release_min) ? release_gap : release_min;
   wire [frst_pkg::CNT_W-1:0] high_len = frst_pkg::CNT_W'(frst_pkg::SELECT_HIGH_CYC);
   wire cnt_done = (cnt_reg == '0);

   // Sequencer: every wait is a down counter; select and output enable stay high until ready.
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      gen_next   = gen_reg;
      pins_next  = '{restart_n: 1'b1, select_n: 1'b1, output_en_n: 1'b1}; // [RULE10]
      ready_next = 1'b0;
      unique case (state_reg)
         frst_pkg::FRST_SETTLE: begin
            pins_next.restart_n = 1'b0;
            if (cnt_done) begin // [RULE1]
               state_next = frst_pkg::FRST_PULSE;
               cnt_next   = pulse_len - 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         frst_pkg::FRST_PULSE: begin
            pins_next.restart_n = 1'b0; // [RULE6]
            if (cnt_done) begin
               state_next          = frst_pkg::FRST_RELEASE;
               pins_next.restart_n = 1'b1;
               cnt_next            = release_len - 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         frst_pkg::FRST_RELEASE: begin
            // Select is don't-care to the flash here, so it is simply held high.
            if (cnt_done) begin // [RULE3] [RULE4]
               state_next = frst_pkg::FRST_HIGH;
               cnt_next   = high_len - 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         frst_pkg::FRST_HIGH: begin
            if (cnt_done) begin // [RULE2] [RULE5]
               state_next = frst_pkg::FRST_READY;
               ready_next = 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         frst_pkg::FRST_READY: begin
            ready_next = 1'b1;
            if (warm_req) begin
               state_next = frst_pkg::FRST_PULSE;
               gen_next   = newer_gen;
               ready_next = 1'b0;
               pins_next.restart_n = 1'b0;
               cnt_next = (newer_gen ? frst_pkg::CNT_W'(frst_pkg::NEW_PULSE_CYC) :
                  frst_pkg::CNT_W'(PULSE_OLD_CYC)) - 1'b1;
            end else begin
               // Select is driven from user requests and released between them.
               pins_next.select_n    = ~acc_select; // [RULE9]
               pins_next.output_en_n = ~acc_read;
            end
         end
         default: begin
            state_next = frst_pkg::FRST_SETTLE;
         end
      endcase
   end

   // The settle count starts full at reset, so power-up waits its whole span.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= frst_pkg::FRST_SETTLE;
         cnt_reg   <= frst_pkg::CNT_W'(SETTLE_CYC);
         gen_reg   <= 1'b1;
         pins_reg  <= '{restart_n: 1'b0, select_n: 1'b1, output_en_n: 1'b1};
         ready_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         gen_reg   <= gen_next;
         pins_reg  <= pins_next;
         ready_reg <= ready_next;
      end
   end

   assign pins  = pins_reg;
   assign ready = ready_reg;

endmodule : frst_sequencer

/* File: design/frst_pkg.sv */
package frst_pkg;

   // Timing figures in their own units, as printed.
   localparam int unsigned CLK_PERIOD_PS        = 10000;
   localparam int unsigned NEW_SUPPLY_SETTLE_NS = 300000;
   localparam int unsigned OLD_SUPPLY_SETTLE_NS = 35000;
   localparam int unsigned NEW_PULSE_NS         = 200;
   localparam int unsigned OLD_PULSE_NS         = 35000;
   localparam int unsigned NEW_RELEASE_NS       = 50;
   localparam int unsigned OLD_RELEASE_NS       = 200;
   localparam int unsigned ASSERT_TO_SELECT_NS  = 35000;
   localparam int unsigned SELECT_HIGH_NS       = 20;

   // Least times round up to whole cycles, never below one.
   function automatic int unsigned frst_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : frst_cyc

   localparam int unsigned NEW_SUPPLY_SETTLE_CYC = frst_cyc(NEW_SUPPLY_SETTLE_NS);
   localparam int unsigned OLD_SUPPLY_SETTLE_CYC = frst_cyc(OLD_SUPPLY_SETTLE_NS);
   localparam int unsigned NEW_PULSE_CYC         = frst_cyc(NEW_PULSE_NS);
   localparam int unsigned OLD_PULSE_CYC         = frst_cyc(OLD_PULSE_NS);
   localparam int unsigned NEW_RELEASE_CYC       = frst_cyc(NEW_RELEASE_NS);
   localparam int unsigned OLD_RELEASE_CYC       = frst_cyc(OLD_RELEASE_NS);
   localparam int unsigned ASSERT_TO_SELECT_CYC  = frst_cyc(ASSERT_TO_SELECT_NS);
   localparam int unsigned SELECT_HIGH_CYC       = frst_cyc(SELECT_HIGH_NS);

   localparam int unsigned CNT_W = 16;

   // Sequencer states, Gray coded along the path.
   typedef enum logic [2:0] {
      FRST_SETTLE  = 3'b000,
      FRST_PULSE   = 3'b001,
      FRST_RELEASE = 3'b011,
      FRST_HIGH    = 3'b010,
      FRST_READY   = 3'b110
   } frst_state_e;

   // Flash control pins, all active low at the pins.
   typedef struct packed {
      logic restart_n;
      logic select_n;
      logic output_en_n;
   } frst_pins_s;

endpackage : frst_pkg

/* File: testbench/frst_flash_model.sv */
`timescale 1ns/10ps
// Flash side: counts accesses that a falling select edge starts.
module frst_flash_model (
   input  frst_pkg::frst_pins_s pins,    // Flash pins.
   output int                   acc_cnt  // Accesses begun.
);
   initial acc_cnt = 0;
   // Select is disregarded while restart is low, so those edges never start an access.
   always @(negedge pins.select_n) if (pins.restart_n === 1'b1) acc_cnt++;
endmodule : frst_flash_model

/* File: testbench/frst_sequencer_asserts.sv */
`timescale 1ns/10ps
module frst_sequencer_asserts #(
   parameter int unsigned SUPPLY_NEW_CYC = 50,
   parameter int unsigned ASSERT_CYC     = 60
) (
   input logic                 sys_clk,    // Clock.
   input logic                 arst_n,     // Reset.
   input logic                 newer_gen,  // Timing set.
   input logic                 warm_req,   // Restart ask.
   input logic                 acc_select, // Select ask.
   input logic                 acc_read,   // Read ask.
   input frst_pkg::frst_pins_s pins,       // Flash pins.
   input logic                 ready       // Ready.
);
   int lo_cnt, hi_cnt, ast_cnt, pwr_cnt;
   // Counters give the waits in whole cycles, so long times need no unrolled repeats.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) {lo_cnt, hi_cnt, ast_cnt, pwr_cnt} <= '0;
      else begin
         lo_cnt  <= pins.restart_n ? 0 : lo_cnt + 1;
         hi_cnt  <= pins.restart_n ? hi_cnt + 1 : 0;
         ast_cnt <= (!pins.restart_n && lo_cnt == 0) ? 1 : ast_cnt + 1;
         pwr_cnt <= pwr_cnt + 1;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   property p_gate; !ready |-> pins.select_n && pins.output_en_n; endproperty
   a_gate: assert property (p_gate) else $error("pin low before ready");
   property p_settle; $fell(pins.select_n) || $fell(pins.output_en_n) |->
      pwr_cnt >= SUPPLY_NEW_CYC; endproperty
   a_settle: assert property (p_settle) else $error("access before settle");
   property p_ast; $fell(pins.select_n) |-> ast_cnt >= ASSERT_CYC; endproperty
   a_ast: assert property (p_ast) else $error("select soon after restart");
   property p_pulse; $rose(pins.restart_n) |-> lo_cnt >= 20; endproperty
   a_pulse: assert property (p_pulse) else $error("restart pulse short");
   property p_post; $fell(pins.select_n) |-> hi_cnt >= 5; endproperty
   a_post: assert property (p_post) else $error("select soon after release");
   property p_ceh; $rose(ready) |-> pins.select_n && $past(pins.select_n, 2)
      && $past(pins.output_en_n, 2); endproperty
   a_ceh: assert property (p_ceh) else $error("select high too short");
   property p_warm; ready && warm_req |=> !pins.restart_n && !ready; endproperty
   a_warm: assert property (p_warm) else $error("warm restart not started");
   property p_follow; ready && $past(ready) |-> pins.select_n == !$past(acc_select)
      && pins.output_en_n == !$past(acc_read); endproperty
   a_follow: assert property (p_follow) else $error("pins do not follow");
   c_ready: cover property ($rose(ready));
   c_warm: cover property (ready && warm_req);
   c_acc: cover property ($fell(pins.select_n));
endmodule : frst_sequencer_asserts
bind frst_sequencer frst_sequencer_asserts #(.SUPPLY_NEW_CYC(SUPPLY_NEW_CYC),
   .ASSERT_CYC(ASSERT_CYC)) chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
   .newer_gen(newer_gen), .warm_req(warm_req), .acc_select(acc_select),
   .acc_read(acc_read), .pins(pins), .ready(ready));

/* File: testbench/tb_flash_reset_first_access_timing.sv */
`timescale 1ns/10ps
module tb_flash_reset_first_access_timing;
   logic sys_clk = 1'b0, arst_n = 1'b0, newer_gen = 1'b1, warm_req = 1'b0, ready;
   logic acc_select = 1'b0, acc_read = 1'b0, sel_q = 1'b0, rd_q = 1'b0, rdy_q = 1'b0;
   logic es_q = 1'b1;
   logic [31:0] lfsr = 32'ha996;
   frst_pkg::frst_pins_s pins;
   int errors = 0, cmp_count = 0, acc_cnt, exp_acc = 0, lo, hi;
   always #5 sys_clk = ~sys_clk;
   frst_sequencer #(.SUPPLY_NEW_CYC(50), .SUPPLY_OLD_CYC(50), .PULSE_OLD_CYC(40),
      .ASSERT_CYC(60)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .newer_gen(newer_gen),
      .warm_req(warm_req), .acc_select(acc_select), .acc_read(acc_read), .pins(pins),
      .ready(ready));
   frst_flash_model flash_u (.pins(pins), .acc_cnt(acc_cnt));
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s exp %0h got %0h", name, exp, got);
      end
   endtask : cmp
   task automatic final_report();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // One cycle: check the pins against the inputs taken last edge, then drive new ones.
   task automatic step(input logic ena, input logic wrm);
      logic es;
      @(posedge sys_clk);
      #1;
      es = (rdy_q && ready) ? ~sel_q : 1'b1;
      if (es_q && !es) exp_acc++;
      es_q = es;
      if (rdy_q && ready) cmp("pins", {es, ~rd_q}, {pins.select_n, pins.output_en_n});
      lo += !pins.restart_n;
      hi += pins.restart_n && !ready;
      rdy_q = ready;
      lfsr = lfsr_next(lfsr);
      sel_q = lfsr[0] & ena;
      rd_q = lfsr[1] & ena;
      acc_select = sel_q;
      acc_read = rd_q;
      warm_req = wrm;
   endtask : step
   // Power-up, then newer and older warm restarts, with refused traffic while waiting.
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      for (int g = 0; g < 3; g++) begin
         lo = 0;
         hi = 0;
         newer_gen = (g != 2);
         step(1'b0, g > 0);
         step(1'b1, 1'b0);
         for (int i = 0; i < 2000 && ready !== 1'b1; i++) step(1'b1, 1'b0);
         if (ready !== 1'b1) begin
            errors++;
            final_report();
         end
         cmp("pulse", 32'h1, lo >= (g == 2 ? 40 : 20));
         cmp("release", 32'h1, hi >= (g == 2 ? 20 : 5));
         cmp("assert", 32'h1, lo + hi >= 60);
         repeat (30) step(1'b1, 1'b0);
      end
      step(1'b0, 1'b1);
      repeat (3) step(1'b1, 1'b0);
      arst_n = 1'b0;
      #1;
      cmp("reset", 32'h3, pins);
      cmp("accesses", exp_acc, acc_cnt);
      final_report();
   end
endmodule : tb_flash_reset_first_access_timing
